// ==== host_iface_pkg.sv ====
// shared constants, carriers and helpers for the host interface front end
package host_iface_pkg;

  typedef enum logic [1:0] {
    MODE_UART,
    MODE_SPI,
    MODE_I2C,
    MODE_I2C_ALT
  } iface_mode_t;

  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [7:0] data;
    logic valid;
  } uart_byte_t;

  // clock figures
  localparam int CLK_KHZ = 100_000;
  localparam int REF_KHZ = 27_120;
  localparam logic [16:0] REF_STEP = 17'(REF_KHZ);
  localparam logic [16:0] REF_MOD = 17'(CLK_KHZ);

  // serial link top rate and the shortest sck half period it implies
  localparam int SPI_MAX_KBPS = 10_000;
  localparam int SPI_HALF_CYC = CLK_KHZ / (2 * SPI_MAX_KBPS);

  // select pins settle through two sync stages before being latched
  localparam logic [1:0] SELECT_SETTLE = 2'h3;

  // register addresses seen over the serial link
  localparam logic [6:0] FIFO_ADDR = 7'h05;
  localparam logic [6:0] RATE_ADDR = 7'h3B;

  // rate register layout and values
  localparam int PRESCALE_MSB = 7;
  localparam int PRESCALE_LSB = 5;
  localparam int DIVIDER_MSB = 4;
  localparam int DIVIDER_LSB = 0;
  localparam logic [7:0] RATE_RESET = 8'h7A;
  localparam logic [7:0] RATE_LOW_EXAMPLE = 8'hFA;
  localparam logic [12:0] DIV_OFFSET_LOW = 13'h0001;
  localparam logic [12:0] DIV_OFFSET_HIGH = 13'h0021;

  function automatic iface_mode_t decode_mode(input logic hi, input logic lo);
    unique case ({hi, lo})
      2'b00: decode_mode = MODE_UART;
      2'b10: decode_mode = MODE_SPI;
      2'b01: decode_mode = MODE_I2C;
      2'b11: decode_mode = MODE_I2C_ALT;
    endcase
  endfunction

  // bit period in reference clock ticks, at most 64 * 64
  function automatic logic [12:0] rate_period(input logic [7:0] r);
    logic [2:0] pre;
    logic [12:0] div;
    pre = r[PRESCALE_MSB:PRESCALE_LSB];
    div = 13'(r[DIVIDER_MSB:DIVIDER_LSB]);
    if (pre == 3'h0) begin
      rate_period = div + DIV_OFFSET_LOW;
    end else begin
      rate_period = (div + DIV_OFFSET_HIGH) << (pre - 3'h1);
    end
  endfunction

endpackage

// ==== host_iface_select_spi_slave.sv ====
// host interface select, pin routing, serial register slave and uart
// Summary of operation
// - reset and re-detect interface on power events
// - select pins decode uart, spi, i2c, alternate
// - shared pins routed per selected interface
// - device is slave; host drives clock
// - serial link works up to ten Mbit/s
// - slave select high holds serial logic reset
// - every serial link byte shifted most significant first
// - sample on rising edge, change on falling
// - first byte: address bits, read flag lsb
// - read returns each address's data byte later
// - write is address then data; output ignored
// - write address increments except fifo address
// - uart starts at default rate after reset
// - rate register write retimes the uart; only spi mode writes it, so uart mode runs at RATE_RESET unless a write lands in the power event cycle
// - prescale factors and divider ranges per table
// - low rate example code selects low rate
// - tabulated rates stay within error bound
// - bit rate formula from reference clock
// - uart char: start, eight lsb-first, stop
`timescale 1ns/1ps
module host_iface_select_spi_slave
  import host_iface_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic power_up_restart,
  input wire logic iface_select_lo,
  input wire logic iface_select_hi,
  input wire logic shared_pin_zero_in,
  input wire logic shared_pin_one_in,
  input wire logic shared_pin_two_in,
  input wire logic shared_pin_three_in,
  output logic shared_pin_zero_out,
  output logic shared_pin_zero_oe,
  output logic shared_pin_one_out,
  output logic shared_pin_one_oe,
  output logic shared_pin_two_out,
  output logic shared_pin_two_oe,
  output logic shared_pin_three_out,
  output logic shared_pin_three_oe,
  output iface_mode_t iface_mode,
  output logic iface_ready,
  output reg_req_t reg_req,
  input wire logic [7:0] reg_rd_data,
  output logic [7:0] uart_rate_reg,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output uart_byte_t rx_byte,
  output logic i2c_scl_level,
  output logic i2c_sda_level,
  output logic bus_addr_bit_one,
  output logic bus_addr_bit_two
);

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

  // sync index: 0..3 shared pins, 4 select lo, 5 select hi
  typedef struct packed {
    logic [5:0] meta;
    logic [5:0] sync;
    logic sck_prev;
    logic rx_prev;
    logic [1:0] settle;
    logic ready;
    iface_mode_t mode;
    logic [2:0] bit_cnt;
    logic [7:0] sh_in;
    logic first;
    logic is_read;
    logic [6:0] addr;
    logic load_pend;
    logic [7:0] tx_byte;
    logic [6:0] miso_sh;
    logic miso;
    reg_req_t req;
    logic [7:0] rate;
    rx_state_t rx_st;
    logic [2:0] rx_cnt;
    logic [7:0] rx_sh;
    uart_byte_t rx_out;
    logic tx_busy;
    logic [3:0] tx_cnt;
    logic [8:0] tx_sh;
    logic tx_line;
    logic tx_rdy;
    logic [3:0] pin_out;
    logic [3:0] pin_oe;
    logic [3:0] i2c_lv;
  } main_state_t;

  main_state_t st_reg;
  main_state_t st_next;
  logic sck_rise;
  logic sck_fall;
  logic spi_on;
  logic spi_hold;
  logic uart_on;
  logic rx_tick;
  logic tx_tick;
  logic rx_restart;
  logic tx_restart;
  logic [7:0] byte_in;

  assign spi_on = st_reg.ready && st_reg.mode == MODE_SPI;
  assign spi_hold = !spi_on || st_reg.sync[3];
  assign uart_on = st_reg.ready && st_reg.mode == MODE_UART;
  assign sck_rise = !st_reg.sck_prev && st_reg.sync[1];
  assign sck_fall = st_reg.sck_prev && !st_reg.sync[1];
  assign byte_in = {st_reg.sh_in[6:0], st_reg.sync[0]};
  assign rx_restart = uart_on && st_reg.rx_st == RX_IDLE &&
    st_reg.rx_prev && !st_reg.sync[0];
  assign tx_restart = tx_valid && st_reg.tx_rdy;

  uart_bit_timer rx_timer (
    .clk(clk),
    .reset_n(reset_n),
    .rate(st_reg.rate),
    .restart(rx_restart),
    .half(1'b1),
    .tick(rx_tick)
  );

  uart_bit_timer tx_timer (
    .clk(clk),
    .reset_n(reset_n),
    .rate(st_reg.rate),
    .restart(tx_restart),
    .half(1'b0),
    .tick(tx_tick)
  );

  always_comb begin
    st_next = st_reg;
    st_next.meta = {iface_select_hi, iface_select_lo, shared_pin_three_in,
      shared_pin_two_in, shared_pin_one_in, shared_pin_zero_in};
    st_next.sync = st_reg.meta;
    st_next.sck_prev = st_reg.sync[1];
    st_next.rx_prev = st_reg.sync[0];
    st_next.req.wr = 1'b0;
    st_next.req.rd = 1'b0;
    st_next.load_pend = 1'b0;
    st_next.rx_out.valid = 1'b0;

    // interface type caught once after each power event, then frozen
    if (power_up_restart) begin
      st_next.settle = SELECT_SETTLE;
      st_next.ready = 1'b0;
      st_next.rate = RATE_RESET;
    end else if (st_reg.settle != 2'h0) begin
      st_next.settle = st_reg.settle - 2'h1;
      if (st_reg.settle == 2'h1) begin
        st_next.mode = decode_mode(st_reg.sync[5], st_reg.sync[4]);
        st_next.ready = 1'b1;
      end
    end

    // serial slave; clock is the host's, sampled here
    if (spi_hold) begin
      st_next.bit_cnt = 3'h0;
      st_next.first = 1'b1;
      st_next.is_read = 1'b0;
      st_next.addr = 7'h00;
      st_next.tx_byte = 8'h00;
    end else begin
      if (sck_rise) begin
        st_next.sh_in = byte_in;
        st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
        if (st_reg.bit_cnt == 3'h7) begin
          if (st_reg.first || st_reg.is_read) begin
            st_next.first = 1'b0;
            st_next.addr = byte_in[7:1];
            st_next.is_read = st_reg.first ? byte_in[0] : st_reg.is_read;
            if (st_reg.first ? byte_in[0] : st_reg.is_read) begin
              st_next.req.rd = 1'b1;
              st_next.req.addr = byte_in[7:1];
              st_next.load_pend = 1'b1;
            end
          end else begin
            st_next.req.wr = 1'b1;
            st_next.req.addr = st_reg.addr;
            st_next.req.wdata = byte_in;
            if (st_reg.addr == RATE_ADDR) begin
              st_next.rate = byte_in;
            end
            if (st_reg.addr != FIFO_ADDR) begin
              st_next.addr = st_reg.addr + 7'h01;
            end
          end
        end
      end
      // read data lands a cycle after the request, well before next fall
      if (st_reg.load_pend) begin
        st_next.tx_byte = (st_reg.req.addr == RATE_ADDR) ?
          st_reg.rate : reg_rd_data;
      end
      if (sck_fall) begin
        if (st_reg.bit_cnt == 3'h0) begin
          st_next.miso = st_reg.tx_byte[7];
          st_next.miso_sh = st_reg.tx_byte[6:0];
        end else begin
          st_next.miso = st_reg.miso_sh[6];
          st_next.miso_sh = {st_reg.miso_sh[5:0], 1'b0};
        end
      end
    end

    // uart receive, lsb first, checked at mid bit
    unique case (st_reg.rx_st)
      RX_IDLE: begin
        if (rx_restart) begin
          st_next.rx_st = RX_START;
        end
      end
      RX_START: begin
        if (rx_tick) begin
          st_next.rx_st = st_reg.sync[0] ? RX_IDLE : RX_DATA;
          st_next.rx_cnt = 3'h0;
        end
      end
      RX_DATA: begin
        if (rx_tick) begin
          st_next.rx_sh = {st_reg.sync[0], st_reg.rx_sh[7:1]};
          st_next.rx_cnt = st_reg.rx_cnt + 3'h1;
          if (st_reg.rx_cnt == 3'h7) begin
            st_next.rx_st = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (rx_tick) begin
          st_next.rx_st = RX_IDLE;
          st_next.rx_out.valid = st_reg.sync[0];
          st_next.rx_out.data = st_reg.rx_sh;
        end
      end
    endcase
    if (!uart_on) begin
      st_next.rx_st = RX_IDLE;
    end

    // uart transmit: start bit now, then data and stop on each tick
    if (tx_restart) begin
      st_next.tx_busy = 1'b1;
      st_next.tx_line = 1'b0;
      st_next.tx_sh = {1'b1, tx_data};
      st_next.tx_cnt = 4'hA;
    end else if (st_reg.tx_busy && tx_tick) begin
      if (st_reg.tx_cnt == 4'h1) begin
        st_next.tx_busy = 1'b0;
      end else begin
        st_next.tx_line = st_reg.tx_sh[0];
        st_next.tx_sh = {1'b1, st_reg.tx_sh[8:1]};
      end
      st_next.tx_cnt = st_reg.tx_cnt - 4'h1;
    end
    if (!uart_on) begin
      st_next.tx_busy = 1'b0;
      st_next.tx_line = 1'b1;
    end
    st_next.tx_rdy = uart_on && !st_next.tx_busy && !tx_restart;

    // pin routing; the i2c engine lives elsewhere, its pins stay inputs
    st_next.pin_out = 4'h0;
    st_next.pin_oe = 4'h0;
    if (spi_on) begin
      st_next.pin_out[2] = st_next.miso;
      st_next.pin_oe[2] = !st_reg.sync[3];
    end else if (uart_on) begin
      st_next.pin_out[2] = st_next.tx_line;
      st_next.pin_oe[2] = 1'b1;
    end
    st_next.i2c_lv = 4'h0;
    if (st_reg.ready && st_reg.mode == MODE_I2C) begin
      st_next.i2c_lv = {st_reg.sync[1], st_reg.sync[3], st_reg.sync[2],
        st_reg.sync[0]};
    end else if (st_reg.ready && st_reg.mode == MODE_I2C_ALT) begin
      st_next.i2c_lv = {st_reg.sync[1], st_reg.sync[2], st_reg.sync[3],
        st_reg.sync[0]};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
      st_reg.settle <= SELECT_SETTLE;
      st_reg.rate <= RATE_RESET;
      st_reg.first <= 1'b1;
      st_reg.tx_line <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign shared_pin_zero_out = st_reg.pin_out[0];
  assign shared_pin_zero_oe = st_reg.pin_oe[0];
  assign shared_pin_one_out = st_reg.pin_out[1];
  assign shared_pin_one_oe = st_reg.pin_oe[1];
  assign shared_pin_two_out = st_reg.pin_out[2];
  assign shared_pin_two_oe = st_reg.pin_oe[2];
  assign shared_pin_three_out = st_reg.pin_out[3];
  assign shared_pin_three_oe = st_reg.pin_oe[3];
  assign iface_mode = st_reg.mode;
  assign iface_ready = st_reg.ready;
  assign reg_req = st_reg.req;
  assign uart_rate_reg = st_reg.rate;
  assign tx_ready = st_reg.tx_rdy;
  assign rx_byte = st_reg.rx_out;
  assign i2c_scl_level = st_reg.i2c_lv[3];
  assign i2c_sda_level = st_reg.i2c_lv[2];
  assign bus_addr_bit_two = st_reg.i2c_lv[1];
  assign bus_addr_bit_one = st_reg.i2c_lv[0];

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  restart_drop_a: assert property (
    power_up_restart |=> !st_reg.ready ##2 !st_reg.ready)
    else $error("interface not re-detected after power event");
  select_decode_a: assert property (
    $rose(st_reg.ready) |->
      st_reg.mode == decode_mode($past(st_reg.sync[5]), $past(st_reg.sync[4])))
    else $error("select pins decoded wrongly");
  mode_frozen_a: assert property (
    st_reg.ready && !power_up_restart |=> $stable(st_reg.mode))
    else $error("interface type changed while latched");
  spi_hold_reset_a: assert property (
    spi_hold |=> st_reg.bit_cnt == 3'h0 && st_reg.first)
    else $error("serial state not held with select high");
  miso_edge_a: assert property (
    !spi_hold && !$past(spi_hold) && $changed(st_reg.miso) |-> $past(sck_fall))
    else $error("miso changed away from falling edge");
  msb_first_a: assert property (
    !spi_hold && sck_fall && st_reg.bit_cnt == 3'h0 |=>
      st_reg.miso == $past(st_reg.tx_byte[7]))
    else $error("byte not started with most significant bit");
  read_flag_a: assert property (
    st_reg.req.rd |-> st_reg.is_read && st_reg.addr == st_reg.req.addr)
    else $error("read issued without read flag");
  addr_incr_a: assert property (
    st_reg.req.wr |-> st_reg.addr == ((st_reg.req.addr == FIFO_ADDR) ?
      FIFO_ADDR : 7'(st_reg.req.addr + 7'h01)))
    else $error("write address step wrong");
  rate_write_a: assert property (
    st_reg.req.wr && st_reg.req.addr == RATE_ADDR |->
      st_reg.rate == st_reg.req.wdata)
    else $error("rate register not updated by write");
  tx_start_a: assert property (
    tx_restart |=> !st_reg.tx_line && !st_reg.tx_rdy)
    else $error("character not opened by low start bit");

  read_cmd_c: cover property (st_reg.req.rd ##[1:200] st_reg.req.rd);
  fifo_burst_c: cover property (
    st_reg.req.wr && st_reg.req.addr == FIFO_ADDR ##[1:200]
    st_reg.req.wr && st_reg.req.addr == FIFO_ADDR);
  low_rate_c: cover property (st_reg.rate == RATE_LOW_EXAMPLE);
  rx_char_c: cover property (st_reg.rx_out.valid);

endmodule

// ==== host_iface_select_spi_slave_test.sv ====
// self-checking bench for the host interface front end
`timescale 1ns/1ps
module host_iface_select_spi_slave_test
  import host_iface_pkg::*;
;
  // bit time of the default rate, from the rate formula, in clk cycles
  localparam int BIT_TICKS =
    (int'(RATE_RESET[4:0]) + 33) << (int'(RATE_RESET[7:5]) - 1);
  localparam int BIT_CYC = (BIT_TICKS * CLK_KHZ + REF_KHZ / 2) / REF_KHZ;
  // select hi, lo, pins 3..0, mode, {scl, sda, addr1, addr2}, tx ready
  localparam logic [12:0] ROWS [6] = '{
    {1'h0, 1'h0, 4'hf, 2'h0, 4'h0, 1'h1},
    {1'h1, 1'h0, 4'hf, 2'h1, 4'h0, 1'h0},
    {1'h0, 1'h1, 4'ha, 2'h2, 4'hc, 1'h0},
    {1'h0, 1'h1, 4'h5, 2'h2, 4'h3, 1'h0},
    {1'h1, 1'h1, 4'ha, 2'h3, 4'h9, 1'h0},
    {1'h1, 1'h1, 4'h6, 2'h3, 4'hc, 1'h0}};

  logic clk = 1'b0;
  logic reset_n;
  logic restart;
  logic sel_lo;
  logic sel_hi;
  logic [3:0] pv;
  logic [1:0] src;
  logic rx_line;
  logic [7:0] tx_data;
  logic tx_valid;
  logic [3:0] p_in, p_out, p_oe;
  iface_mode_t mode;
  logic ready, tx_ready, scl, sda, a1, a2;
  reg_req_t reg_req;
  uart_byte_t rx_byte;
  logic [7:0] rate, rd_data, rx_got;
  logic mosi, sck, slave_select_n, pin2_wire;
  logic pin2_last;
  logic [7:0] mem [128];
  logic [14:0] wq [$];
  int rx_cnt = 0;
  int fails = 0;
  int samples_checked = 0;

  always #5 clk = ~clk;

  // a released line shows the inverse of its last level, never a guess
  assign pin2_wire = p_oe[2] ? p_out[2] : ~pin2_last;
  always @(posedge clk) if (p_oe[2]) pin2_last <= p_out[2];
  assign p_in = src == 2'h1 ? {slave_select_n, pin2_wire, sck, mosi} :
                src == 2'h2 ? {pv[3], pin2_wire, pv[1], rx_line} : pv;
  assign rd_data = mem[reg_req.addr];

  always @(posedge clk) begin
    if (reg_req.wr) begin
      wq.push_back({reg_req.addr, reg_req.wdata});
      mem[reg_req.addr] <= reg_req.wdata;
    end
    if (rx_byte.valid) begin
      rx_got <= rx_byte.data;
      rx_cnt <= rx_cnt + 1;
    end
  end

  host_iface_select_spi_slave i_host_iface_select_spi_slave (
    .clk(clk), .reset_n(reset_n), .power_up_restart(restart),
    .iface_select_lo(sel_lo), .iface_select_hi(sel_hi),
    .shared_pin_zero_in(p_in[0]), .shared_pin_one_in(p_in[1]),
    .shared_pin_two_in(p_in[2]), .shared_pin_three_in(p_in[3]),
    .shared_pin_zero_out(p_out[0]), .shared_pin_zero_oe(p_oe[0]),
    .shared_pin_one_out(p_out[1]), .shared_pin_one_oe(p_oe[1]),
    .shared_pin_two_out(p_out[2]), .shared_pin_two_oe(p_oe[2]),
    .shared_pin_three_out(p_out[3]), .shared_pin_three_oe(p_oe[3]),
    .iface_mode(mode), .iface_ready(ready), .reg_req(reg_req),
    .reg_rd_data(rd_data), .uart_rate_reg(rate), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_byte(rx_byte),
    .i2c_scl_level(scl), .i2c_sda_level(sda),
    .bus_addr_bit_one(a1), .bus_addr_bit_two(a2));

  spi_host_model i_spi_host_model (
    .clk(clk), .miso(pin2_wire), .mosi(mosi), .sck(sck),
    .slave_select_n(slave_select_n));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic latch(input logic hi, input logic lo);
    sel_hi = hi;
    sel_lo = lo;
    restart = 1'b1;
    @(negedge clk);
    restart = 1'b0;
    repeat (6) @(negedge clk);
  endtask

  task automatic spi(input logic [7:0] tx, output logic [7:0] rx);
    i_spi_host_model.xfer(tx, 8, rx);
  endtask

  task automatic results();
    $display("counts: %0d checked, %0d mismatched", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #1_000_000;
    fails++;
    results();
  end

  initial begin
    logic [12:0] row;
    logic [7:0] b, r1, r2;
    logic [9:0] bits;
    int n, cnt0;
    reset_n = 1'b0;
    restart = 1'b0;
    sel_lo = 1'b0;
    sel_hi = 1'b0;
    pv = 4'h0;
    src = 2'h0;
    rx_line = 1'b1;
    tx_data = 8'h00;
    tx_valid = 1'b0;
    pin2_last = 1'b0;
    for (int i = 0; i < 128; i++) mem[i] = 8'(i) ^ 8'hc3;
    repeat (3) @(negedge clk);
    chk(16'(p_oe), 16'h0, "oe in reset");
    chk(16'(rate), 16'(RATE_RESET), "rate in reset");
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    for (int r = 0; r < 6; r++) begin
      row = ROWS[r];
      pv = row[10:7];
      latch(row[12], row[11]);
      chk(16'(ready), 16'h1, "ready");
      chk(16'(mode), 16'(row[6:5]), "mode");
      chk(16'({scl, sda, a1, a2}), 16'(row[4:1]), "levels");
      chk(16'(tx_ready), 16'(row[0]), "tx ready");
      chk(16'({p_oe, p_out}), 16'(row[0]) * 16'h0044, "pin oe");
    end
    sel_hi = 1'b0;
    sel_lo = 1'b0;
    repeat (6) @(negedge clk);
    chk(16'(mode), 16'(MODE_I2C_ALT), "mode kept");
    $display("test mode select done");

    src = 2'h1;
    latch(1'b1, 1'b0);
    i_spi_host_model.sel(1'b1);
    i_spi_host_model.xfer(8'hff, 3, b);
    i_spi_host_model.sel(1'b0);
    wq.delete();
    i_spi_host_model.sel(1'b1);
    spi({7'h10, 1'b0}, b);
    for (int i = 0; i < 3; i++) spi(8'ha1 + 8'(8'h11 * i), b);
    i_spi_host_model.sel(1'b0);
    repeat (8) @(negedge clk);
    chk(16'(wq.size()), 16'h3, "write count");
    for (int i = 0; i < 3; i++)
      chk(16'(wq[i]), {1'h0, 7'h10 + 7'(i), 8'ha1 + 8'(8'h11 * i)},
          "burst write");
    wq.delete();
    i_spi_host_model.sel(1'b1);
    spi({FIFO_ADDR, 1'b0}, b);
    for (int i = 0; i < 3; i++) spi(8'h40 + 8'(i), b);
    i_spi_host_model.sel(1'b0);
    repeat (8) @(negedge clk);
    chk(16'(wq.size()), 16'h3, "fifo count");
    for (int i = 0; i < 3; i++)
      chk(16'(wq[i]), {1'h0, FIFO_ADDR, 8'h40 + 8'(i)},
          "fifo write");
    $display("test serial write done");

    i_spi_host_model.half = 20;
    i_spi_host_model.sel(1'b1);
    spi({7'h20, 1'b1}, b);
    spi({7'h21, 1'b1}, r1);
    spi(8'h00, r2);
    i_spi_host_model.sel(1'b0);
    i_spi_host_model.half = 6;
    chk(16'(r1), 16'(8'h20 ^ 8'hc3), "read first");
    chk(16'(r2), 16'(8'h21 ^ 8'hc3), "read last");
    i_spi_host_model.sel(1'b1);
    spi({RATE_ADDR, 1'b0}, b);
    spi(RATE_LOW_EXAMPLE, b);
    i_spi_host_model.sel(1'b0);
    repeat (4) @(negedge clk);
    chk(16'(rate), 16'(RATE_LOW_EXAMPLE), "rate write");
    i_spi_host_model.sel(1'b1);
    spi({RATE_ADDR, 1'b1}, b);
    spi(8'h00, r1);
    i_spi_host_model.sel(1'b0);
    chk(16'(r1), 16'(RATE_LOW_EXAMPLE), "rate read");
    $display("test serial read and rate done");

    src = 2'h2;
    latch(1'b0, 1'b0);
    chk(16'(rate), 16'(RATE_RESET), "rate restart");
    tx_data = 8'ha6;
    tx_valid = 1'b1;
    n = 0;
    while (tx_ready !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk(16'(tx_ready), 16'h1, "tx ready wait");
    @(negedge clk);
    tx_valid = 1'b0;
    n = 0;
    while (pin2_wire !== 1'b0 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    chk(16'(pin2_wire), 16'h0, "start bit");
    // sampling mid-bit leaves half a bit of margin for rate error
    repeat (BIT_CYC / 2) @(negedge clk);
    for (int i = 0; i < 10; i++) begin
      bits[i] = pin2_wire;
      repeat (BIT_CYC) @(negedge clk);
    end
    chk(16'(bits), 16'({1'b1, 8'ha6, 1'b0}), "tx frame");
    chk(16'(tx_ready), 16'h1, "tx idle again");
    cnt0 = rx_cnt;
    bits = {1'b1, 8'h3c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_line = bits[i];
      repeat (BIT_CYC) @(negedge clk);
    end
    repeat (BIT_CYC) @(negedge clk);
    chk(16'(rx_cnt - cnt0), 16'h1, "rx count");
    chk(16'(rx_got), 16'h3c, "rx data");
    $display("test uart done");
    results();
  end
endmodule

// ==== spi_host_model.sv ====
// serial link master standing in for the host controller
`timescale 1ns/1ps
module spi_host_model (
  input wire logic clk,
  input wire logic miso,
  output logic mosi,
  output logic sck,
  output logic slave_select_n
);
  // sck half period in clk cycles; 6 gives 60 ns, inside the 10 Mbit/s top
  // rate; the bench may raise it to act as a slow host
  int half = 6;

  initial begin
    mosi = 1'b0;
    sck = 1'b0;
    slave_select_n = 1'b1;
  end

  task automatic sel(input logic on);
    repeat (half) @(negedge clk);
    slave_select_n = ~on;
    repeat (half) @(negedge clk);
  endtask

  // the host owns the clock; a short count leaves a partial byte behind
  task automatic xfer(input logic [7:0] tx, input int nbits,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      mosi = tx[i];
      repeat (half) @(negedge clk);
      sck = 1'b1;
      rx[i] = miso;
      repeat (half) @(negedge clk);
      sck = 1'b0;
    end
  endtask
endmodule

// ==== uart_bit_timer.sv ====
// bit timer: derives the reference tick rate and divides it per rate setting
`timescale 1ns/1ps
module uart_bit_timer
  import host_iface_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] rate,
  input wire logic restart,
  input wire logic half,
  output logic tick
);

  typedef struct packed {
    logic [16:0] acc;
    logic [12:0] cnt;
    logic tick;
  } timer_state_t;

  timer_state_t st_reg;
  timer_state_t st_next;
  logic [16:0] acc_sum;
  logic ref_en;
  logic [12:0] period;

  assign acc_sum = st_reg.acc + REF_STEP;
  assign ref_en = acc_sum >= REF_MOD;
  assign period = rate_period(rate);
  assign tick = st_reg.tick;

  // fractional accumulator gives the reference tick rate on average; the
  // 10 ns jitter is far inside the character tolerance
  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    st_next.acc = ref_en ? acc_sum - REF_MOD : acc_sum;
    if (restart) begin
      st_next.cnt = half ? (period >> 1) : period;
    end else if (ref_en) begin
      if (st_reg.cnt <= 13'h0001) begin
        st_next.tick = 1'b1;
        st_next.cnt = period;
      end else begin
        st_next.cnt = st_reg.cnt - 13'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  period_load_a: assert property (
    !restart && ref_en && st_reg.cnt <= 13'h0001 |=>
      st_reg.cnt == $past(period) && st_reg.tick)
    else $error("bit period not reloaded from rate fields");

endmodule
